// *** bnc_pkg.sv ***
// Shared constants and types of the buzzer note controller
package bnc_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int          BNC_ADR_W     = 20;
  localparam int          BNC_IDX_W     = BNC_ADR_W - 2;
  localparam int          BNC_DAT_W     = 32;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [17:0] BNC_IDX_NOTE_A = 18'h0a040;
  localparam logic [17:0] BNC_IDX_NOTE_B = 18'h0a044;
  localparam logic [17:0] BNC_IDX_CFG    = 18'h0a048;
  localparam logic [17:0] BNC_IDX_POW    = 18'h0a049;
  localparam logic [17:0] BNC_IDX_TU     = 18'h0a04a;
  localparam logic [17:0] BNC_IDX_EVT    = 18'h0a04b;
  localparam logic [17:0] BNC_IDX_MASK   = 18'h0a04c;

  // Field offsets inside one note block
  localparam logic [1:0]  BNC_F_FRQ_L    = 2'h0;
  localparam logic [1:0]  BNC_F_FRQ_H    = 2'h1;
  localparam logic [1:0]  BNC_F_DUR      = 2'h2;
  localparam logic [1:0]  BNC_F_PAU      = 2'h3;

  // ---------------------------------------------------------------
  // Bit positions
  // ---------------------------------------------------------------
  localparam int          BNC_CFG_EN     = 7;
  localparam int          BNC_CFG_INV    = 6;
  localparam int          BNC_CFG_IEB    = 5;
  localparam int          BNC_CFG_IEA    = 4;
  localparam int          BNC_CFG_FB     = 3;
  localparam int          BNC_CFG_FA     = 2;
  localparam int          BNC_CFG_GOB    = 1;
  localparam int          BNC_CFG_GOA    = 0;
  localparam int          BNC_TU_HI      = 7;
  localparam int          BNC_TU_LO      = 6;
  localparam int          BNC_TU_BASE    = 4;
  localparam int          BNC_TU_IEP     = 1;
  localparam int          BNC_TU_FP      = 0;
  localparam int          BNC_EV_A       = 0;
  localparam int          BNC_EV_B       = 1;
  localparam int          BNC_EV_P       = 2;
  localparam int          BNC_EV_W       = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  BNC_RST_BYTE   = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          BNC_CLK_PERIOD_NS = 100;
  localparam int          BNC_MS_NS         = 1000000;
  localparam int          BNC_MS_CYCLES     = BNC_MS_NS / BNC_CLK_PERIOD_NS;
  // Half of the /64 and /32 prescale, square wave toggles twice a period
  localparam logic [5:0]  BNC_PRE_HALF_SLOW = 6'h20;
  localparam logic [5:0]  BNC_PRE_HALF_FAST = 6'h10;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] divider;
    logic [7:0]  dur;
    logic [7:0]  pause;
  } bnc_note_s;

  typedef enum logic [1:0] {
    BNC_ST_IDLE,
    BNC_ST_TONE,
    BNC_ST_PAUSE
  } bnc_state_e;

endpackage

// *** bnc_unit_tick.sv ***
// Time-unit tick generator: one pulse per 1, 2, 4 or 8 ms
module bnc_unit_tick #(
  parameter int MS_CYCLES = bnc_pkg::BNC_MS_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       restart,
  input  wire logic [1:0] unit_sel,
  // Result
  output logic            tick
);
  import bnc_pkg::*;

  localparam int CW = $clog2(MS_CYCLES);

  logic [CW-1:0] cyc_reg;
  logic [2:0]    ms_reg;
  logic          ms_end;
  logic [2:0]    ms_last;

  assign ms_end  = (cyc_reg == CW'(MS_CYCLES - 1));
  assign ms_last = 3'((4'h1 << unit_sel) - 4'h1);

  always_ff @(posedge sys_clk) begin
    if (!rst_b || restart || ms_end) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || restart) begin
      ms_reg <= 3'h0;
      tick   <= 1'b0;
    end else if (ms_end) begin
      ms_reg <= (ms_reg >= ms_last) ? 3'h0 : ms_reg + 3'h1;
      tick   <= (ms_reg >= ms_last);
    end else begin
      tick   <= 1'b0;
    end
  end

endmodule

// *** bnc_tone_gen.sv ***
// Square tone generator: clock / (32 or 64) / (divider + 1)
module bnc_tone_gen (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        run,
  input  wire logic        fast_base,
  input  wire logic [11:0] divider,
  // Result
  output logic             wave
);
  import bnc_pkg::*;

  logic [5:0]  pre_reg;
  logic [11:0] div_reg;
  logic        pre_end;

  assign pre_end = (pre_reg == (fast_base ? BNC_PRE_HALF_FAST : BNC_PRE_HALF_SLOW) - 6'h1);

  always_ff @(posedge sys_clk) begin
    if (!rst_b || !run || pre_end) begin
      pre_reg <= 6'h0;
    end else begin
      pre_reg <= pre_reg + 6'h1;
    end
  end

  // Toggle per divider wrap gives a full period of prescale*(divider+1)
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !run) begin
      div_reg <= 12'h000;
      wave    <= 1'b0;
    end else if (pre_end) begin
      if (div_reg >= divider) begin
        div_reg <= 12'h000;
        wave    <= ~wave;
      end else begin
        div_reg <= div_reg + 12'h001;
      end
    end
  end

endmodule

// *** bnc_top.sv ***
// Buzzer note controller: registers, note sequencer, window timer
//
// What this block does
// R1: With the note B end interrupt enabled, the end of note B sets its end flag, cleared by writing 0.
// R2: With the note A end interrupt enabled, the end of note A sets its end flag, held until written 0.
// R3: Writing 1 to the note B start bit starts note B; writing 0 changes nothing.
// R4: The note B start command clears itself when note B has finished.
// R5: Writing 1 to the note A start bit starts note A; writing 0 has no effect.
// R6: The note A start command clears itself when note A has finished.
// R7: Both start bits written 1 together play note A and then note B.
// R8: The note B busy bit reads 1 while the tone output plays note B.
// R9: The note A busy bit reads 1 while note A plays, and the start bit positions read back as busy.
// R10: The enable bit lets the controller run and the polarity bit inverts the tone output.
// R11: The interrupt is raised while any end flag or window flag is set with its enable at 1.
// R12: Tone frequency is the clock divided by 32 or 64, then by the 12-bit divider plus one.
// R13: Duration and pause are the 8-bit counts times a time unit of 1, 2, 4 or 8 ms.
// R14: The window timer starts with either note and counts in the same time unit.
module bnc_top #(
  parameter int MS_CYCLES = bnc_pkg::BNC_MS_CYCLES
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [bnc_pkg::BNC_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [bnc_pkg::BNC_DAT_W-1:0] wb_dat_i,
  output logic      [bnc_pkg::BNC_DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  // Buzzer side
  output logic                               tone_output,
  output logic                               power_window,
  // Interrupt
  output logic                               irq
);
  import bnc_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic idx_hit(input logic [BNC_IDX_W-1:0] idx,
                                   input logic [17:0]          want);
    return idx == want;
  endfunction

  function automatic logic [17:0] note_idx(input logic n, input logic [1:0] f);
    return (n ? BNC_IDX_NOTE_B : BNC_IDX_NOTE_A) + {16'h0000, f};
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bnc_note_s           note_reg [2];
  logic                en_reg;
  logic                inv_reg;
  logic [1:0]          ie_reg;
  logic [1:0]          flag_reg;
  logic [1:0]          go_reg;
  logic [7:0]          pow_reg;
  logic [1:0]          tu_reg;
  logic                base_reg;
  logic                iep_reg;
  logic                fp_reg;
  logic [BNC_EV_W-1:0] evt_reg;
  logic [BNC_EV_W-1:0] mask_reg;
  bnc_state_e          state_reg;
  logic                cur_reg;
  logic [7:0]          cnt_reg;
  logic                pow_run_reg;
  logic [7:0]          pow_cnt_reg;

  logic                acc;
  logic                wr;
  logic                rd;
  logic [BNC_IDX_W-1:0] idx;
  logic [7:0]          wd;
  logic [7:0]          rd_byte;
  logic                wr_cfg;
  logic [1:0]          go_set;
  logic [1:0]          done;
  logic [1:0]          busy;
  logic                note_end;
  logic                pow_end;
  logic                tick;
  logic                restart;
  logic                wave;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Answer one cycle after the request, ack dropped the next cycle
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i && wb_sel_i[0];
  assign rd  = acc && !wb_we_i;
  assign idx = wb_adr_i[BNC_ADR_W-1:2];
  assign wd  = wb_dat_i[7:0];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // Unmapped words read as zero, writes there are dropped
  always_comb begin
    rd_byte = BNC_RST_BYTE;
    if (idx_hit(idx, BNC_IDX_CFG)) begin
      // R9 busy read back
      rd_byte = {en_reg, inv_reg, ie_reg[1], ie_reg[0], flag_reg[1], flag_reg[0], busy[1], busy[0]};
    end else if (idx_hit(idx, BNC_IDX_POW)) begin
      rd_byte = pow_reg;
    end else if (idx_hit(idx, BNC_IDX_TU)) begin
      rd_byte = {tu_reg, 1'b0, base_reg, 2'b00, iep_reg, fp_reg};
    end else if (idx_hit(idx, BNC_IDX_EVT)) begin
      rd_byte = {5'h00, evt_reg};
    end else if (idx_hit(idx, BNC_IDX_MASK)) begin
      rd_byte = {5'h00, mask_reg};
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (idx_hit(idx, note_idx(n[0], BNC_F_FRQ_L))) begin
          rd_byte = note_reg[n].divider[7:0];
        end else if (idx_hit(idx, note_idx(n[0], BNC_F_FRQ_H))) begin
          rd_byte = {4'h0, note_reg[n].divider[11:8]};
        end else if (idx_hit(idx, note_idx(n[0], BNC_F_DUR))) begin
          rd_byte = note_reg[n].dur;
        end else if (idx_hit(idx, note_idx(n[0], BNC_F_PAU))) begin
          rd_byte = note_reg[n].pause;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= {{(BNC_DAT_W-8){1'b0}}, rd_byte};
    end else begin
      wb_dat_o <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Note settings
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int n = 0; n < 2; n++) begin
        note_reg[n] <= '0;
      end
    end else if (wr) begin
      for (int n = 0; n < 2; n++) begin
        if (idx_hit(idx, note_idx(n[0], BNC_F_FRQ_L))) begin
          note_reg[n].divider[7:0] <= wd;
        end
        if (idx_hit(idx, note_idx(n[0], BNC_F_FRQ_H))) begin
          note_reg[n].divider[11:8] <= wd[3:0];
        end
        if (idx_hit(idx, note_idx(n[0], BNC_F_DUR))) begin
          note_reg[n].dur <= wd;
        end
        if (idx_hit(idx, note_idx(n[0], BNC_F_PAU))) begin
          note_reg[n].pause <= wd;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------
  assign wr_cfg = wr && idx_hit(idx, BNC_IDX_CFG);

  // R10 enable and polarity
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      en_reg  <= 1'b0;
      inv_reg <= 1'b0;
      ie_reg  <= 2'b00;
    end else if (wr_cfg) begin
      en_reg  <= wd[BNC_CFG_EN];
      inv_reg <= wd[BNC_CFG_INV];
      ie_reg  <= {wd[BNC_CFG_IEB], wd[BNC_CFG_IEA]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pow_reg  <= BNC_RST_BYTE;
      tu_reg   <= 2'b00;
      base_reg <= 1'b0;
      iep_reg  <= 1'b0;
      mask_reg <= '0;
    end else if (wr) begin
      if (idx_hit(idx, BNC_IDX_POW)) begin
        pow_reg <= wd;
      end
      if (idx_hit(idx, BNC_IDX_TU)) begin
        tu_reg   <= wd[BNC_TU_HI:BNC_TU_LO];
        base_reg <= wd[BNC_TU_BASE];
        iep_reg  <= wd[BNC_TU_IEP];
      end
      if (idx_hit(idx, BNC_IDX_MASK)) begin
        mask_reg <= wd[BNC_EV_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Start commands
  // ---------------------------------------------------------------
  // A start needs the enable written in the same word, zeros ignored
  // R3 note B start
  // R5 note A start
  assign go_set = (wr_cfg && wd[BNC_CFG_EN]) ? {wd[BNC_CFG_GOB], wd[BNC_CFG_GOA]} : 2'b00;

  // R4 note B self-clear
  // R6 note A self-clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      go_reg <= 2'b00;
    end else if (!en_reg && go_set == 2'b00) begin
      go_reg <= 2'b00;
    end else begin
      go_reg <= (go_reg & ~done) | go_set;
    end
  end

  // ---------------------------------------------------------------
  // Note sequencer
  // ---------------------------------------------------------------
  assign note_end = (state_reg == BNC_ST_PAUSE) && (cnt_reg == 8'h00);
  assign done     = note_end ? (cur_reg ? 2'b10 : 2'b01) : 2'b00;
  // R8 busy for note B
  // R9 busy for note A
  assign busy     = (state_reg == BNC_ST_TONE) ? (cur_reg ? 2'b10 : 2'b01) : 2'b00;
  assign restart  = (state_reg == BNC_ST_IDLE) && en_reg && (go_reg != 2'b00);

  // R7 note A ahead of note B
  // R13 duration then pause in time units
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= BNC_ST_IDLE;
      cur_reg   <= 1'b0;
      cnt_reg   <= 8'h00;
    end else if (!en_reg) begin
      state_reg <= BNC_ST_IDLE;
    end else begin
      case (state_reg)
        BNC_ST_IDLE: begin
          if (go_reg[0]) begin
            cur_reg   <= 1'b0;
            cnt_reg   <= note_reg[0].dur;
            state_reg <= BNC_ST_TONE;
          end else if (go_reg[1]) begin
            cur_reg   <= 1'b1;
            cnt_reg   <= note_reg[1].dur;
            state_reg <= BNC_ST_TONE;
          end
        end
        BNC_ST_TONE: begin
          if (cnt_reg == 8'h00) begin
            cnt_reg   <= note_reg[cur_reg].pause;
            state_reg <= BNC_ST_PAUSE;
          end else if (tick) begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        BNC_ST_PAUSE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= BNC_ST_IDLE;
          end else if (tick) begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= BNC_ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power window timer
  // ---------------------------------------------------------------
  assign pow_end = pow_run_reg && (pow_cnt_reg == 8'h00);

  // R14 window start on any start command write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pow_run_reg <= 1'b0;
      pow_cnt_reg <= 8'h00;
    end else if (go_set != 2'b00) begin
      pow_run_reg <= 1'b1;
      pow_cnt_reg <= pow_reg;
    end else if (pow_end) begin
      pow_run_reg <= 1'b0;
    end else if (pow_run_reg && tick) begin
      pow_cnt_reg <= pow_cnt_reg - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  // Writing 1 keeps a flag, a set in the clearing cycle wins
  // R1 note B end flag
  // R2 note A end flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flag_reg <= 2'b00;
    end else begin
      flag_reg <= (wr_cfg ? (flag_reg & {wd[BNC_CFG_FB], wd[BNC_CFG_FA]}) : flag_reg)
                  | (done & ie_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fp_reg <= 1'b0;
    end else begin
      fp_reg <= ((wr && idx_hit(idx, BNC_IDX_TU)) ? (fp_reg & wd[BNC_TU_FP]) : fp_reg) | pow_end;
    end
  end

  // Raw events, cleared by reading, new events win
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      evt_reg <= '0;
    end else begin
      evt_reg <= ((rd && idx_hit(idx, BNC_IDX_EVT)) ? '0 : evt_reg)
                 | {pow_end, done[1], done[0]};
    end
  end

  // R11 interrupt request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(flag_reg & ie_reg)) || (fp_reg && iep_reg) || (|(evt_reg & mask_reg));
    end
  end

  // ---------------------------------------------------------------
  // Tone path
  // ---------------------------------------------------------------
  bnc_unit_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .restart  (restart),
    .unit_sel (tu_reg),
    .tick     (tick)
  );

  // R12 tone divider
  bnc_tone_gen u_tone (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .run       (busy != 2'b00),
    .fast_base (base_reg),
    .divider   (note_reg[cur_reg].divider),
    .wave      (wave)
  );

  // R10 inverted output idles high
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tone_output  <= 1'b0;
      power_window <= 1'b0;
    end else begin
      tone_output  <= (wave && busy != 2'b00) ^ inv_reg;
      power_window <= pow_run_reg;
    end
  end

endmodule

// *** bnc_top_sva.sv ***
// Port-level checker of the buzzer note controller
module bnc_top_sva #(
  parameter int MS_CYCLES = bnc_pkg::BNC_MS_CYCLES
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [19:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tone_output,
  input wire logic        power_window,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_go;
    s_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i[19:2] == 18'h0a048 && wb_dat_i[7] && wb_dat_i[1:0] != 2'h0;
  endsequence
  chk_ack_one_cycle: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
  chk_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  chk_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read data upper bits set");
  chk_unmapped_read: assert property (s_req ##0 !wb_we_i && wb_adr_i[19:2] > 18'h0a04c |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // A start only counts when the same write enables, window shows two cycles after the taking edge
  chk_cfg_no_go_quiet: assert property (s_req ##0 wb_we_i && wb_adr_i[19:2] == 18'h0a048 && !wb_dat_i[7]
    |=> ##1 !$rose(power_window)) else $error("window started while disabled");
  chk_window_on_start: assert property (s_go |-> ##[1:3] power_window) else $error("window did not open");
  // Every cause of irq is cleared only by a bus access, so a fall follows an ack
  chk_irq_falls_bus: assert property ($fell(irq) |-> $past(wb_ack_o)) else $error("irq dropped without bus access");
  chk_ack_released: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without cycle");
endmodule
bind bnc_top bnc_top_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tone_output(tone_output), .power_window(power_window), .irq(irq));

// *** bnc_buzzer_model.sv ***
// Buzzer element model: measures the tone period at its input
module bnc_buzzer_model (
  input wire logic sys_clk,
  input wire logic tone
);
  timeunit 1ns;
  timeprecision 1ns;
  int   period;
  int   cnt;
  logic tone_q;
  initial begin
    period = 0;
    cnt = 0;
    tone_q = 1'b0;
  end
  // Period counted from rising edge to rising edge
  always @(posedge sys_clk) begin
    cnt++;
    if (tone === 1'b1 && tone_q !== 1'b1) begin
      period = cnt;
      cnt = 0;
    end
    tone_q = tone;
  end
endmodule

// *** tb_buzzer_note_control.sv ***
// Self-checking bench of the buzzer note controller
module tb_buzzer_note_control;
  timeunit 1ns;
  timeprecision 1ns;
  import bnc_pkg::*;
  // Cycles per millisecond in this bench, kept short for run time
  localparam int MS = 20;
  logic        sys_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [19:0] adr = 20'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic        ack, tone, pwin, irq;
  logic [7:0]  rd;
  int          fail_count = 0, tests_run = 0;
  always #50 sys_clk = ~sys_clk;
  bnc_top #(.MS_CYCLES(MS)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tone_output(tone),
    .power_window(pwin), .irq(irq));
  bnc_buzzer_model u_buzz (.sys_clk(sys_clk), .tone(tone));
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic single cycle, released at the edge that sees ack
  task automatic xfer(logic [17:0] idx, logic w, logic [7:0] wd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h0, wd};
    sel <= 4'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_cfg(logic [7:0] m, logic [7:0] v);
    int n;
    n = 0;
    do begin
      xfer(BNC_IDX_CFG, 1'b0, 8'h0);
      n++;
    end while ((rd & m) !== v && n < 400);
    chk("cfg poll", v, rd & m);
  endtask
  task automatic t_reset();
    xfer(18'h0a050, 1'b1, 8'hff);
    xfer(18'h0a050, 1'b0, 8'h0);
    chk("unmapped", 8'h00, rd);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("cfg reset", 8'h00, rd);
    $display("reset test done");
  endtask
  task automatic t_note_a();
    for (int i = 0; i < 8; i++) xfer(BNC_IDX_NOTE_A + 18'(i), 1'b1, (i % 4 == 2) ? 8'h0a : {7'h0, i % 4 != 1});
    xfer(BNC_IDX_TU, 1'b1, 8'h10);
    xfer(BNC_IDX_CFG, 1'b1, 8'h91);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("a busy", 8'h01, rd & 8'h03);
    repeat (150) @(posedge sys_clk);
    chk("tone period", 8'd64, 8'(u_buzz.period));
    wait_cfg(8'h05, 8'h04);
    chk("irq flag", 8'h01, {7'h0, irq});
    xfer(BNC_IDX_CFG, 1'b1, 8'h90);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("flag clear", 8'h90, rd);
    chk("irq off", 8'h00, {7'h0, irq});
    $display("note a test done");
  endtask
  task automatic t_melody();
    // Slow /64 base, 1 ms unit
    xfer(BNC_IDX_TU, 1'b1, 8'h00);
    xfer(BNC_IDX_CFG, 1'b1, 8'hb3);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("a first", 8'h01, rd & 8'h03);
    // Two rising edges of note A fall inside its tone phase
    repeat (200) @(posedge sys_clk);
    chk("slow period", 8'd128, 8'(u_buzz.period));
    wait_cfg(8'h03, 8'h02);
    wait_cfg(8'h0f, 8'h0c);
    xfer(BNC_IDX_CFG, 1'b1, 8'hb0);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("b clear", 8'hb0, rd);
    xfer(BNC_IDX_EVT, 1'b0, 8'h0);
    chk("events", 8'h03, rd & 8'h03);
    xfer(BNC_IDX_EVT, 1'b0, 8'h0);
    chk("events read clear", 8'h00, rd);
    $display("melody test done");
  endtask
  task automatic t_mask();
    int n;
    n = 0;
    xfer(BNC_IDX_MASK, 1'b1, 8'h01);
    // Window of two 2 ms units
    xfer(BNC_IDX_POW, 1'b1, 8'h02);
    xfer(BNC_IDX_TU, 1'b1, 8'h50);
    xfer(BNC_IDX_CFG, 1'b1, 8'h81);
    while (pwin === 1'b1 && n < 250) begin
      @(posedge sys_clk);
      n++;
    end
    chk("window length", 8'(4 * MS), 8'((n >= 4 * MS && n <= 6 * MS) ? 4 * MS : n));
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("masked irq", 8'h01, {7'h0, irq});
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("no flag", 8'h80, rd);
    xfer(BNC_IDX_EVT, 1'b0, 8'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    $display("mask test done");
  endtask
  task automatic t_polarity();
    xfer(BNC_IDX_CFG, 1'b1, 8'hc0);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("zero start", 8'hc0, rd);
    chk("inverted idle", 8'h01, {7'h0, tone});
    xfer(BNC_IDX_CFG, 1'b1, 8'h41);
    xfer(BNC_IDX_CFG, 1'b0, 8'h0);
    chk("disabled", 8'h40, rd);
    $display("polarity test done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_note_a();
    t_melody();
    t_mask();
    t_polarity();
    tally_and_finish();
  end
endmodule
